// File: web_aux_pkg.sv
`default_nettype none
package web_aux_pkg;

  // Data widths
  localparam int SPD_W = 16;
  localparam int PCT_W = 10;
  localparam int TIME_W = 20;
  localparam int FUNC_W = 3;
  localparam int NUM_INPUTS = 7;
  localparam int OSEL_W = 2;
  localparam int PROD_W = SPD_W + PCT_W;

  // Percent settings are in 0.1 % steps
  localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8;
  localparam logic [PCT_W-1:0] PCT_ZERO = 10'h000;
  localparam logic [PCT_W-1:0] HYST_BAND = 10'h014;

  // Speed and time constants
  localparam logic [SPD_W-1:0] SPD_ZERO = 16'h0000;
  localparam logic [SPD_W-1:0] SPD_ONE = 16'h0001;
  localparam logic [SPD_W-1:0] SPD_MAX = 16'hFFFF;
  localparam logic [TIME_W-1:0] TIME_ZERO = 20'h00000;

  // Function codes of the assignable input terminals
  localparam logic [FUNC_W-1:0] IN_FN_NONE = 3'h0;
  localparam logic [FUNC_W-1:0] IN_FN_QUICK_STOP = 3'h1;
  localparam logic [FUNC_W-1:0] IN_FN_WEB_INCH = 3'h2;
  localparam logic [FUNC_W-1:0] IN_FN_TENSION_INHIBIT = 3'h3;
  localparam logic [FUNC_W-1:0] IN_FN_SPLICE = 3'h4;

  // Function codes of the assignable outputs
  localparam logic [OSEL_W-1:0] OUT_FN_NONE = 2'h0;
  localparam logic [OSEL_W-1:0] OUT_FN_SPEED_MATCH = 2'h1;

  // Ramp time base: times are counted in 10 ms units
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS = 10000000;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Factory defaults of the settings, for the controller that drives them
  localparam logic DEF_CHECK_ON = 1'b0;
  localparam logic [PCT_W-1:0] DEF_THRESHOLD = 10'h000;
  localparam logic [TIME_W-1:0] DEF_QUICK_STOP_TIME = 20'h00064;
  localparam logic [PCT_W-1:0] DEF_INCH_SPEED = 10'h064;
  localparam logic DEF_RAMP_SELECT = 1'b1;
  localparam logic [TIME_W-1:0] DEF_INCH_TIME = 20'h001F4;
  localparam logic [PCT_W-1:0] DEF_SPLICE_PCT = 10'h000;

  // Operating modes
  typedef enum logic [3:0] {
    MODE_RUN = 4'b0001,
    MODE_INCH = 4'b0010,
    MODE_QSTOP = 4'b0100,
    MODE_HOLD = 4'b1000
  } mode_t;

  // Speed times percent, unscaled
  function automatic logic [PROD_W-1:0] pct_product(input logic [SPD_W-1:0] v, input logic [PCT_W-1:0] p);
    return {{PCT_W{1'b0}}, v} * {{SPD_W{1'b0}}, p};
  endfunction

  // Speed times percent, scaled and saturated
  function automatic logic [SPD_W-1:0] pct_of(input logic [SPD_W-1:0] v, input logic [PCT_W-1:0] p);
    logic [PROD_W-1:0] q;
    q = pct_product(v, p) / {{SPD_W{1'b0}}, PCT_FULL};
    return (q > {{PCT_W{1'b0}}, SPD_MAX}) ? SPD_MAX : q[SPD_W-1:0];
  endfunction

  // Saturating speed addition
  function automatic logic [SPD_W-1:0] sat_add(input logic [SPD_W-1:0] a, input logic [SPD_W-1:0] b);
    logic [SPD_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[SPD_W] ? SPD_MAX : s[SPD_W-1:0];
  endfunction

  // True when any terminal assigned to a function is on
  function automatic logic in_active(input logic [NUM_INPUTS-1:0] pins,
                                     input logic [NUM_INPUTS*FUNC_W-1:0] sel,
                                     input logic [FUNC_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (pins[i] && (sel[i*FUNC_W +: FUNC_W] == code)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage
`default_nettype wire

// File: ramp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ramp_if;
  logic [web_aux_pkg::SPD_W-1:0] target;
  logic [web_aux_pkg::SPD_W-1:0] scale;
  logic [web_aux_pkg::TIME_W-1:0] accel_time;
  logic [web_aux_pkg::TIME_W-1:0] decel_time;
  logic [web_aux_pkg::SPD_W-1:0] speed;
  logic at_target;

  modport ctrl(output target, output scale, output accel_time, output decel_time, input speed, input at_target);
  modport ramp(input target, input scale, input accel_time, input decel_time, output speed, output at_target);
endinterface
`default_nettype wire

// File: speed_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module speed_ramp #(
  parameter int TICK_CYCLES = web_aux_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  ramp_if.ramp rp
);
  localparam int CNT_W = $clog2(TICK_CYCLES);
  localparam int CRD_W = web_aux_pkg::TIME_W + 2;

  logic [CNT_W-1:0] tick_cnt_r;
  logic [CNT_W-1:0] tick_cnt_nxt;
  logic [CRD_W-1:0] credit_r;
  logic [CRD_W-1:0] credit_nxt;
  logic [web_aux_pkg::SPD_W-1:0] speed_r;
  logic [web_aux_pkg::SPD_W-1:0] speed_nxt;
  wire logic tick;
  wire logic going_up;
  wire logic [web_aux_pkg::TIME_W-1:0] active_time;
  wire logic immediate;
  wire logic step;
  wire logic [CRD_W-1:0] credit_dec;
  wire logic [CRD_W-1:0] credit_inc;

  // Time base and ramp direction; a full-scale swing takes the active time
  assign tick = (tick_cnt_r == CNT_W'(TICK_CYCLES - 1));
  assign tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
  assign going_up = (rp.target > speed_r);
  assign active_time = going_up ? rp.accel_time : rp.decel_time;
  assign immediate = (active_time == web_aux_pkg::TIME_ZERO);
  assign step = (credit_r >= {2'b00, active_time});
  assign credit_dec = step ? {2'b00, active_time} : '0;
  assign credit_inc = tick ? {{(CRD_W - web_aux_pkg::SPD_W){1'b0}}, rp.scale} : '0;
  assign credit_nxt = rp.at_target ? '0 : credit_r - credit_dec + credit_inc;

  // One unit of speed each time the credit reaches the active time, zero time jumps at once
  always_comb begin
    speed_nxt = speed_r;
    if (immediate) begin
      speed_nxt = rp.target;
    end else if (step && !rp.at_target) begin
      speed_nxt = going_up ? speed_r + web_aux_pkg::SPD_ONE : speed_r - web_aux_pkg::SPD_ONE;
    end
  end

  assign rp.speed = speed_r;
  assign rp.at_target = (speed_r == rp.target);

  // State registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
      credit_r <= '0;
      speed_r <= web_aux_pkg::SPD_ZERO;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      credit_r <= credit_nxt;
      speed_r <= speed_nxt;
    end
  end
endmodule
`default_nettype wire

// File: speed_match_detect.sv
`timescale 1ns/1ps
`default_nettype none
module speed_match_detect (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic check_on,
  input wire logic [web_aux_pkg::SPD_W-1:0] cmd_speed,
  input wire logic [web_aux_pkg::SPD_W-1:0] act_speed,
  input wire logic [web_aux_pkg::PCT_W-1:0] threshold,
  output logic flag_r
);
  logic flag_nxt;
  wire logic [web_aux_pkg::SPD_W-1:0] deviation;
  wire logic [web_aux_pkg::PCT_W-1:0] clear_level;
  wire logic [web_aux_pkg::PROD_W-1:0] dev_scaled;
  wire logic [web_aux_pkg::PROD_W-1:0] set_limit;
  wire logic [web_aux_pkg::PROD_W-1:0] clear_limit;

  // Magnitude of the deviation, either sign alike
  assign deviation = (cmd_speed >= act_speed) ? cmd_speed - act_speed : act_speed - cmd_speed;
  // Limits as percent of the present command, clear point one band lower
  assign clear_level = (threshold > web_aux_pkg::HYST_BAND) ? threshold - web_aux_pkg::HYST_BAND
                                                            : web_aux_pkg::PCT_ZERO;
  assign dev_scaled = web_aux_pkg::pct_product(deviation, web_aux_pkg::PCT_FULL);
  assign set_limit = web_aux_pkg::pct_product(cmd_speed, threshold);
  assign clear_limit = web_aux_pkg::pct_product(cmd_speed, clear_level);

  // Set above the level, hold inside the band, off when judgment is disabled
  always_comb begin
    flag_nxt = flag_r;
    if (!check_on) begin
      flag_nxt = 1'b0;
    end else if (dev_scaled > set_limit) begin
      flag_nxt = 1'b1;
    end else if (dev_scaled <= clear_limit) begin
      flag_nxt = 1'b0;
    end
  end

  // Flag register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule
`default_nettype wire

// File: web_speed_aux_functions.sv
`timescale 1ns/1ps
`default_nettype none
module web_speed_aux_functions #(
  parameter int TICK_CYCLES = web_aux_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [web_aux_pkg::NUM_INPUTS-1:0] assignable_inputs,
  input wire logic [web_aux_pkg::NUM_INPUTS*web_aux_pkg::FUNC_W-1:0] input_func_sel,
  input wire logic [web_aux_pkg::SPD_W-1:0] line_speed_cmd,
  input wire logic [web_aux_pkg::SPD_W-1:0] actual_line_speed,
  input wire logic [web_aux_pkg::SPD_W-1:0] motor_top_speed,
  input wire logic speed_match_check_on,
  input wire logic [web_aux_pkg::PCT_W-1:0] speed_match_threshold,
  input wire logic [web_aux_pkg::TIME_W-1:0] quick_stop_time,
  input wire logic [web_aux_pkg::PCT_W-1:0] inch_speed_pct,
  input wire logic inch_ramp_select,
  input wire logic [web_aux_pkg::TIME_W-1:0] inch_accel_time,
  input wire logic [web_aux_pkg::TIME_W-1:0] inch_decel_time,
  input wire logic [web_aux_pkg::TIME_W-1:0] base_accel_time,
  input wire logic [web_aux_pkg::TIME_W-1:0] base_decel_time,
  input wire logic [web_aux_pkg::PCT_W-1:0] splice_pct,
  input wire logic [web_aux_pkg::OSEL_W-1:0] assignable_output_sel,
  input wire logic [web_aux_pkg::OSEL_W-1:0] open_collector_output_sel,
  output logic [web_aux_pkg::SPD_W-1:0] speed_cmd_out,
  output logic aux_out,
  output logic oc_out,
  output logic speed_match_flag,
  output logic pid_run,
  output logic diameter_calc_on,
  output logic tension_hold,
  output logic splice_active,
  output logic inch_active,
  output logic quick_stop_active,
  output logic standstill
);

  ramp_if rp();

  web_aux_pkg::mode_t mode_r;
  web_aux_pkg::mode_t mode_nxt;
  logic [web_aux_pkg::SPD_W-1:0] qstop_scale_r;
  logic [web_aux_pkg::SPD_W-1:0] qstop_scale_nxt;
  logic aux_out_r;
  logic oc_out_r;
  logic pid_run_r;
  logic diameter_calc_on_r;
  logic tension_hold_r;
  logic splice_active_r;
  logic inch_active_r;
  logic quick_stop_active_r;
  logic standstill_r;
  logic [web_aux_pkg::SPD_W-1:0] target_sel;
  logic [web_aux_pkg::SPD_W-1:0] scale_sel;
  logic [web_aux_pkg::TIME_W-1:0] accel_sel;
  logic [web_aux_pkg::TIME_W-1:0] decel_sel;
  wire logic match_flag;
  wire logic qstop_in;
  wire logic inch_in;
  wire logic inhibit_in;
  wire logic splice_in;
  wire logic in_run;
  wire logic in_inch;
  wire logic in_qstop;
  wire logic in_hold;
  wire logic splice_on;
  wire logic [web_aux_pkg::SPD_W-1:0] inch_target;
  wire logic [web_aux_pkg::SPD_W-1:0] splice_boost;
  wire logic [web_aux_pkg::SPD_W-1:0] run_target;
  wire logic [web_aux_pkg::TIME_W-1:0] inch_accel_sel;
  wire logic [web_aux_pkg::TIME_W-1:0] inch_decel_sel;
  wire logic at_zero;

  // Terminal functions decoded from the assignable inputs
  assign qstop_in = web_aux_pkg::in_active(assignable_inputs, input_func_sel, web_aux_pkg::IN_FN_QUICK_STOP);
  assign inch_in = web_aux_pkg::in_active(assignable_inputs, input_func_sel, web_aux_pkg::IN_FN_WEB_INCH);
  assign inhibit_in = web_aux_pkg::in_active(assignable_inputs, input_func_sel, web_aux_pkg::IN_FN_TENSION_INHIBIT);
  assign splice_in = web_aux_pkg::in_active(assignable_inputs, input_func_sel, web_aux_pkg::IN_FN_SPLICE);

  // Mode decode
  assign in_run = (mode_r == web_aux_pkg::MODE_RUN);
  assign in_inch = (mode_r == web_aux_pkg::MODE_INCH);
  assign in_qstop = (mode_r == web_aux_pkg::MODE_QSTOP);
  assign in_hold = (mode_r == web_aux_pkg::MODE_HOLD);
  assign at_zero = (rp.speed == web_aux_pkg::SPD_ZERO);

  // Inching speed as percent of the top motor speed
  assign inch_target = web_aux_pkg::pct_of(motor_top_speed, inch_speed_pct);

  // Splice boost on the line command, never while inching
  assign splice_on = splice_in && !inch_in && in_run;
  assign splice_boost = web_aux_pkg::pct_of(line_speed_cmd, splice_pct);
  assign run_target = splice_on ? web_aux_pkg::sat_add(line_speed_cmd, splice_boost) : line_speed_cmd;

  // Inching ramp times: dedicated pair or the base pair
  assign inch_accel_sel = inch_ramp_select ? inch_accel_time : base_accel_time;
  assign inch_decel_sel = inch_ramp_select ? inch_decel_time : base_decel_time;

  // Mode sequencing; quick stop wins over inching, inching over normal run
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      web_aux_pkg::MODE_RUN: begin
        if (qstop_in) begin
          mode_nxt = web_aux_pkg::MODE_QSTOP;
        end else if (inch_in) begin
          mode_nxt = web_aux_pkg::MODE_INCH;
        end
      end
      web_aux_pkg::MODE_INCH: begin
        if (qstop_in) begin
          mode_nxt = web_aux_pkg::MODE_QSTOP;
        end else if (!inch_in) begin
          mode_nxt = web_aux_pkg::MODE_RUN;
        end
      end
      web_aux_pkg::MODE_QSTOP: begin
        if (!qstop_in) begin
          mode_nxt = web_aux_pkg::MODE_RUN;
        end else if (at_zero) begin
          mode_nxt = web_aux_pkg::MODE_HOLD;
        end
      end
      web_aux_pkg::MODE_HOLD: begin
        if (!qstop_in) begin
          mode_nxt = web_aux_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_nxt = web_aux_pkg::MODE_RUN;
      end
    endcase
  end

  // Speed at the start of a quick stop sets the slope, so any speed stops in the same time
  always_comb begin
    qstop_scale_nxt = qstop_scale_r;
    if (!in_qstop && (mode_nxt == web_aux_pkg::MODE_QSTOP)) begin
      qstop_scale_nxt = rp.speed;
    end
  end

  // Ramp target, slope scale and ramp times per mode
  always_comb begin
    target_sel = run_target;
    scale_sel = motor_top_speed;
    accel_sel = base_accel_time;
    decel_sel = base_decel_time;
    case (mode_r)
      web_aux_pkg::MODE_RUN: begin
        target_sel = run_target;
      end
      web_aux_pkg::MODE_INCH: begin
        target_sel = inch_target;
        accel_sel = inch_accel_sel;
        decel_sel = inch_decel_sel;
      end
      web_aux_pkg::MODE_QSTOP, web_aux_pkg::MODE_HOLD: begin
        target_sel = web_aux_pkg::SPD_ZERO;
        scale_sel = qstop_scale_r;
        decel_sel = quick_stop_time;
      end
      default: begin
        target_sel = web_aux_pkg::SPD_ZERO;
      end
    endcase
  end

  assign rp.target = target_sel;
  assign rp.scale = scale_sel;
  assign rp.accel_time = accel_sel;
  assign rp.decel_time = decel_sel;

  // Linear ramp generator
  speed_ramp #(
    .TICK_CYCLES(TICK_CYCLES)
  ) speed_ramp_inst (
    .mclk(mclk),
    .resetn(resetn),
    .rp(rp.ramp)
  );

  // Deviation judgment between line command and actual line speed
  speed_match_detect speed_match_detect_inst (
    .mclk(mclk),
    .resetn(resetn),
    .check_on(speed_match_check_on),
    .cmd_speed(line_speed_cmd),
    .act_speed(actual_line_speed),
    .threshold(speed_match_threshold),
    .flag_r(match_flag)
  );

  // Mode and slope registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= web_aux_pkg::MODE_RUN;
      qstop_scale_r <= web_aux_pkg::SPD_ZERO;
    end else begin
      mode_r <= mode_nxt;
      qstop_scale_r <= qstop_scale_nxt;
    end
  end

  // Assignable status outputs follow their function selects
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aux_out_r <= 1'b0;
      oc_out_r <= 1'b0;
    end else begin
      aux_out_r <= (assignable_output_sel == web_aux_pkg::OUT_FN_SPEED_MATCH) && match_flag;
      oc_out_r <= (open_collector_output_sel == web_aux_pkg::OUT_FN_SPEED_MATCH) && match_flag;
    end
  end

  // Loop and status outputs; tension is never released by a quick stop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pid_run_r <= 1'b0;
      diameter_calc_on_r <= 1'b0;
      tension_hold_r <= 1'b0;
      splice_active_r <= 1'b0;
      inch_active_r <= 1'b0;
      quick_stop_active_r <= 1'b0;
      standstill_r <= 1'b0;
    end else begin
      pid_run_r <= !inhibit_in;
      diameter_calc_on_r <= !in_inch;
      tension_hold_r <= in_qstop || in_hold;
      splice_active_r <= splice_on;
      inch_active_r <= in_inch;
      quick_stop_active_r <= in_qstop || in_hold;
      standstill_r <= in_hold;
    end
  end

  assign speed_cmd_out = rp.speed;
  assign speed_match_flag = match_flag;
  assign aux_out = aux_out_r;
  assign oc_out = oc_out_r;
  assign pid_run = pid_run_r;
  assign diameter_calc_on = diameter_calc_on_r;
  assign tension_hold = tension_hold_r;
  assign splice_active = splice_active_r;
  assign inch_active = inch_active_r;
  assign quick_stop_active = quick_stop_active_r;
  assign standstill = standstill_r;

endmodule
`default_nettype wire

// File: web_speed_aux_functions_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module web_speed_aux_functions_assertions (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [web_aux_pkg::NUM_INPUTS-1:0] assignable_inputs,
  input wire logic [web_aux_pkg::NUM_INPUTS*web_aux_pkg::FUNC_W-1:0] input_func_sel,
  input wire logic [web_aux_pkg::SPD_W-1:0] line_speed_cmd,
  input wire logic [web_aux_pkg::SPD_W-1:0] actual_line_speed,
  input wire logic speed_match_check_on,
  input wire logic [web_aux_pkg::PCT_W-1:0] speed_match_threshold,
  input wire logic [web_aux_pkg::OSEL_W-1:0] assignable_output_sel,
  input wire logic [web_aux_pkg::OSEL_W-1:0] open_collector_output_sel,
  input wire logic [web_aux_pkg::SPD_W-1:0] speed_cmd_out,
  input wire logic aux_out,
  input wire logic oc_out,
  input wire logic speed_match_flag,
  input wire logic pid_run,
  input wire logic diameter_calc_on,
  input wire logic tension_hold,
  input wire logic splice_active,
  input wire logic inch_active,
  input wire logic quick_stop_active,
  input wire logic standstill
);
  logic qs_on, inh_on, set_c;
  logic [web_aux_pkg::SPD_W-1:0] dev;
  logic [25:0] dev_k, set_k, clr_k;
  // Own decode of the terminals assigned to quick stop and tension inhibit
  always_comb begin
    qs_on = 1'b0;
    inh_on = 1'b0;
    for (int i = 0; i < web_aux_pkg::NUM_INPUTS; i++) begin
      if (assignable_inputs[i] && input_func_sel[i*3 +: 3] == web_aux_pkg::IN_FN_QUICK_STOP) qs_on = 1'b1;
      if (assignable_inputs[i] && input_func_sel[i*3 +: 3] == web_aux_pkg::IN_FN_TENSION_INHIBIT) inh_on = 1'b1;
    end
  end
  // Deviation magnitude and both thresholds, scaled to 0.1 % steps
  assign dev = (line_speed_cmd >= actual_line_speed) ? line_speed_cmd - actual_line_speed
                                                     : actual_line_speed - line_speed_cmd;
  assign dev_k = 26'(dev) * 26'h00003E8;
  assign set_k = 26'(line_speed_cmd) * 26'(speed_match_threshold);
  assign clr_k = (speed_match_threshold > 10'h014) ?
                 26'(line_speed_cmd) * 26'(speed_match_threshold - 10'h014) : 26'h0000000;
  assign set_c = speed_match_check_on && (dev_k > set_k);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_flag_set: assert property (set_c |=> speed_match_flag)
    else $error("speed match flag not set above level");
  a_flag_clear: assert property (speed_match_check_on && dev_k <= clr_k |=> !speed_match_flag)
    else $error("speed match flag not cleared below band");
  a_flag_band: assert property (speed_match_check_on && !set_c && dev_k > clr_k |=> $stable(speed_match_flag))
    else $error("speed match flag moved inside band");
  a_flag_off: assert property (!speed_match_check_on |=> !speed_match_flag)
    else $error("speed match flag set while judgment off");
  a_aux_flag: assert property (1'b1 |=> aux_out == ($past(speed_match_flag)
    && $past(assignable_output_sel) == web_aux_pkg::OUT_FN_SPEED_MATCH))
    else $error("aux output does not follow flag");
  a_oc_flag: assert property (1'b1 |=> oc_out == ($past(speed_match_flag)
    && $past(open_collector_output_sel) == web_aux_pkg::OUT_FN_SPEED_MATCH))
    else $error("open collector output does not follow flag");
  a_qstop_on: assert property (qs_on ##1 qs_on |=> quick_stop_active && tension_hold)
    else $error("quick stop not entered");
  a_qstop_off: assert property (!qs_on ##1 !qs_on |=> !quick_stop_active && !standstill)
    else $error("quick stop held without terminal");
  a_hold_zero: assert property (standstill |-> speed_cmd_out == web_aux_pkg::SPD_ZERO && tension_hold)
    else $error("standstill with speed or without tension");
  a_inch_diam: assert property (inch_active |-> !diameter_calc_on && !splice_active)
    else $error("diameter or splice active while inching");
  a_pid_follow: assert property (1'b1 |=> pid_run == !$past(inh_on))
    else $error("pid run does not follow inhibit");
endmodule
bind web_speed_aux_functions web_speed_aux_functions_assertions web_speed_aux_functions_assertions_inst (
  .mclk, .resetn, .assignable_inputs, .input_func_sel, .line_speed_cmd, .actual_line_speed,
  .speed_match_check_on, .speed_match_threshold, .assignable_output_sel, .open_collector_output_sel,
  .speed_cmd_out, .aux_out, .oc_out, .speed_match_flag, .pid_run, .diameter_calc_on, .tension_hold,
  .splice_active, .inch_active, .quick_stop_active, .standstill);
`default_nettype wire

// File: seq_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module seq_ctrl_model (
  input wire logic mclk,
  input wire logic qs_req,
  input wire logic inch_req,
  input wire logic splice_req,
  output var logic [web_aux_pkg::NUM_INPUTS-1:0] assignable_inputs,
  output logic [web_aux_pkg::NUM_INPUTS*web_aux_pkg::FUNC_W-1:0] input_func_sel
);
  // Terminal map: 0 quick stop, 1 inch, 2 tension inhibit, 3 splice, rest unused
  assign input_func_sel = {9'h000, web_aux_pkg::IN_FN_SPLICE, web_aux_pkg::IN_FN_TENSION_INHIBIT,
                           web_aux_pkg::IN_FN_WEB_INCH, web_aux_pkg::IN_FN_QUICK_STOP};
  initial assignable_inputs = 7'h00;
  // Terminals change just after the edge; inhibit is held for the whole splice
  always @(posedge mclk) begin
    assignable_inputs <= #1 {3'h0, splice_req, splice_req, inch_req, qs_req};
  end
endmodule
`default_nettype wire

// File: web_speed_aux_functions_test.sv
`timescale 1ns/1ps
`default_nettype none
module web_speed_aux_functions_test;
  logic mclk = 1'b0, resetn = 1'b0, qs_req = 1'b0, inch_req = 1'b0, splice_req = 1'b0;
  logic speed_match_check_on = 1'b0, inch_ramp_select = 1'b1;
  logic [15:0] line_speed_cmd = 16'h0000, actual_line_speed = 16'h0000, motor_top_speed = 16'h0BB8;
  logic [9:0] speed_match_threshold = 10'h064, inch_speed_pct = 10'h0C8, splice_pct = 10'h064;
  logic [19:0] quick_stop_time = 20'h00064, inch_accel_time = 20'h001F4, inch_decel_time = 20'h001F4;
  logic [19:0] base_accel_time = 20'h00000, base_decel_time = 20'h00000;
  logic [1:0] assignable_output_sel = 2'h1, open_collector_output_sel = 2'h0;
  wire logic [6:0] assignable_inputs;
  wire logic [20:0] input_func_sel;
  wire logic [15:0] speed_cmd_out;
  wire logic aux_out, oc_out, speed_match_flag, pid_run, diameter_calc_on, tension_hold;
  wire logic splice_active, inch_active, quick_stop_active, standstill;
  int bad_count = 0, total_checks = 0;
  always #50 mclk = ~mclk;
  seq_ctrl_model seq_ctrl_model_inst (.mclk, .qs_req, .inch_req, .splice_req, .assignable_inputs, .input_func_sel);
  web_speed_aux_functions #(.TICK_CYCLES(10)) web_speed_aux_functions_inst (
    .mclk, .resetn, .assignable_inputs, .input_func_sel, .line_speed_cmd, .actual_line_speed, .motor_top_speed,
    .speed_match_check_on, .speed_match_threshold, .quick_stop_time, .inch_speed_pct, .inch_ramp_select,
    .inch_accel_time, .inch_decel_time, .base_accel_time, .base_decel_time, .splice_pct,
    .assignable_output_sel, .open_collector_output_sel, .speed_cmd_out, .aux_out, .oc_out, .speed_match_flag,
    .pid_run, .diameter_calc_on, .tension_hold, .splice_active, .inch_active, .quick_stop_active, .standstill);
  // Comparison and verdict helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("Checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic reach(input logic [15:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && speed_cmd_out !== exp; i++) step(1);
    check("speed", speed_cmd_out, exp);
  endtask
  // Deviation judgment: enable, set, band, clear, both signs, both outputs
  task automatic t_match;
    line_speed_cmd = 16'h03E8;
    actual_line_speed = 16'h0FA0;
    step(3);
    check("flag off", 16'(speed_match_flag), 16'h0000);
    speed_match_check_on = 1'b1;
    actual_line_speed = 16'h044D;
    step(3);
    check("flag set", 16'(speed_match_flag), 16'h0001);
    check("aux", 16'(aux_out), 16'h0001);
    check("oc unassigned", 16'(oc_out), 16'h0000);
    open_collector_output_sel = 2'h1;
    actual_line_speed = 16'h0442;
    step(3);
    check("flag band", 16'(speed_match_flag), 16'h0001);
    check("oc", 16'(oc_out), 16'h0001);
    actual_line_speed = 16'h039D;
    step(3);
    check("flag clear", 16'(speed_match_flag), 16'h0000);
    actual_line_speed = 16'h037A;
    step(3);
    check("flag low side", 16'(speed_match_flag), 16'h0001);
    speed_match_check_on = 1'b0;
    step(3);
    check("flag disabled", 16'(speed_match_flag), 16'h0000);
    actual_line_speed = line_speed_cmd;
  endtask
  // Quick stop from a given speed: same stop time whatever the speed
  task automatic t_qstop(input logic [15:0] v);
    line_speed_cmd = v;
    reach(v, 8);
    qs_req = 1'b1;
    step(4);
    check("qs active", 16'(quick_stop_active), 16'h0001);
    check("tension hold", 16'(tension_hold), 16'h0001);
    step(896);
    check("still moving", 16'(speed_cmd_out == 16'h0000), 16'h0000);
    reach(16'h0000, 200);
    step(3);
    check("standstill", 16'(standstill), 16'h0001);
    check("hold tension", 16'(tension_hold), 16'h0001);
    check("pid kept", 16'(pid_run), 16'h0001);
    qs_req = 1'b0;
    step(4);
    check("qs released", 16'(quick_stop_active), 16'h0000);
    reach(v, 8);
  endtask
  // Inching with either ramp source, then splice ignored and applied
  task automatic t_inch(input logic sel);
    line_speed_cmd = 16'h0000;
    inch_speed_pct = 10'h0C8;
    reach(16'h0000, 8);
    inch_ramp_select = sel;
    inch_req = 1'b1;
    step(4);
    check("inch", 16'(inch_active), 16'h0001);
    check("diameter", 16'(diameter_calc_on), 16'h0000);
    check("pid inch", 16'(pid_run), 16'h0001);
    if (sel) begin
      step(40);
      check("inch ramping", 16'(speed_cmd_out == 16'h0258), 16'h0000);
      reach(16'h0258, 1200);
    end else begin
      reach(16'h0258, 6);
    end
    // Lower inch speed: exercises the deceleration side of the selected pair
    inch_speed_pct = 10'h064;
    if (sel) begin
      step(40);
      check("inch slowing", 16'(speed_cmd_out == 16'h012C), 16'h0000);
      reach(16'h012C, 700);
    end else begin
      reach(16'h012C, 6);
    end
    line_speed_cmd = 16'h03E8;
    splice_req = 1'b1;
    step(4);
    check("splice in inch", 16'(splice_active), 16'h0000);
    check("inch speed kept", speed_cmd_out, 16'h012C);
    inch_req = 1'b0;
    reach(16'h044C, 10);
    check("splice", 16'(splice_active), 16'h0001);
    check("diameter back", 16'(diameter_calc_on), 16'h0001);
    check("pid inhibited", 16'(pid_run), 16'h0000);
    splice_req = 1'b0;
    reach(16'h03E8, 10);
  endtask
  // Hang guard
  initial begin
    #2000000;
    bad_count++;
    results();
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 resetn = 1'b1;
    step(2);
    t_match();
    t_qstop(16'h03E8);
    t_qstop(16'h0064);
    t_inch(1'b1);
    t_inch(1'b0);
    results();
  end
endmodule
`default_nettype wire
